// File: hdl/xpmc_ctrl.sv
// What this block does
// - Exactly one of four PAD modes
// - Start in AT mode, command mode if autostart; select needs link
// - Stay connect-in-progress until call resolves or recall character is typed
// - Established call sends COM, enters data
// - Recall character escapes to command mode
// - One command after recall, then return, unless that command is clear or a select with link
// - Prompt asterisk on every command mode entry
// - Resume needs link, else ERROR
// - Autostart setting sampled only at restart
// - Escape +++ in command or data mode suspends PAD into AT mode
// - Clear disconnects, CLR CONF (CLR ERR once a recall from CIP has used its one command), stays command
// - D-packet subscription brings link up
// - One channel, modulo 8, 256 byte packets
// - Windows limited to seven outstanding
// - Save writes settings to nonvolatile store
// - Echo data and commands locally in every mode but AT
// - Reject lines over 128 characters
// - Invalid command answered with ERR
//
// Purpose: PAD mode controller and terminal character front end
// Assumes: Terminal bytes are on the clock domain; network flags are
//          asynchronous and synchronised here
// Notes: The packet engine sits outside; this block gates its window
`timescale 1ns/1ps
`default_nettype none
module xpmc_ctrl (
   input wire logic clock,
   input wire logic reset,
   input wire logic enable,
   input wire logic term_valid,
   input wire logic [7:0] term_data,
   output logic term_ready,
   input wire logic cmd_valid,
   input wire xpmc_pkg::xpmc_cmd_e cmd_code,
   input wire logic [7:0] recall_char,
   input wire logic autostart,
   input wire logic dpkt_subscribed,
   input wire logic link_up_pin,
   input wire logic call_ok_pin,
   input wire logic call_fail_pin,
   output logic link_request,
   output logic call_request,
   output logic clear_request,
   output logic save_request,
   output logic line_end,
   output logic line_overflow,
   output logic [7:0] echo_data,
   output logic echo_valid,
   output xpmc_pkg::xpmc_resp_e resp_code,
   output logic resp_valid,
   output logic [2:0] mode,
   output logic pkt_valid,
   input wire logic pkt_ready,
   output logic [7:0] pkt_data,
   input wire logic [3:0] link_outstanding,
   input wire logic [3:0] pkt_outstanding,
   output logic [2:0] send_seq,
   output logic window_open,
   output logic [8:0] pkt_len
);
   // ------
   // Input synchronisers
   // ------
   logic [1:0] link_s;
   logic [1:0] ok_s;
   logic [1:0] fail_s;
   logic link_up;
   logic call_ok;
   logic call_fail;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         link_s <= '0;
         ok_s <= '0;
         fail_s <= '0;
      end
      else if (enable)
      begin
         link_s <= {link_s[0], link_up_pin};
         ok_s <= {ok_s[0], call_ok_pin};
         fail_s <= {fail_s[0], call_fail_pin};
      end
   end
   assign link_up = link_s[1];
   assign call_ok = ok_s[1];
   assign call_fail = fail_s[1];

   // ------
   // Character classification
   // ------
   xpmc_pkg::xpmc_mode_e state;
   xpmc_pkg::xpmc_mode_e next_state;
   xpmc_pkg::xpmc_mode_e ret_mode;
   logic one_shot;
   logic auto_seen;
   logic [1:0] plus_cnt;
   logic [7:0] line_cnt;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic prompt_due;
   logic take;
   logic is_recall;
   logic is_delim;
   logic is_plus;
   logic to_pkt;

   function automatic logic in_pad(input xpmc_pkg::xpmc_mode_e m);
      in_pad = (m == xpmc_pkg::XPMC_CIP) || (m == xpmc_pkg::XPMC_DATA);
   endfunction : in_pad

   assign term_ready = fifo_in_ready;
   assign take = enable && term_valid && fifo_in_ready;
   assign is_recall = in_pad(state) && (term_data == recall_char);
   assign is_delim = (term_data == xpmc_pkg::CH_CR)
      || (term_data == xpmc_pkg::CH_PLUS);
   assign is_plus = (term_data == xpmc_pkg::CH_PLUS);
   // Recall characters and all pluses stay out of the packet stream
   assign to_pkt = take && (state == xpmc_pkg::XPMC_DATA)
      && !is_recall && !is_plus;

   // ------
   // Mode machine
   // ------
   always_comb
   begin
      next_state = state;
      case (state)
         xpmc_pkg::XPMC_AT:
         begin
            if (!auto_seen && autostart)
            begin
               next_state = xpmc_pkg::XPMC_CMD;
            end
            else if (cmd_valid && cmd_code == xpmc_pkg::XPMC_C_RESUME
               && link_up)
            begin
               next_state = xpmc_pkg::XPMC_CMD;
            end
         end
         xpmc_pkg::XPMC_CMD:
         begin
            if (take && plus_cnt == 2'(xpmc_pkg::ESC_LEN - 1) && is_plus)
            begin
               next_state = xpmc_pkg::XPMC_AT;
            end
            else if (cmd_valid)
            begin
               case (cmd_code)
                  xpmc_pkg::XPMC_C_SEL:
                     next_state = link_up ? xpmc_pkg::XPMC_CIP
                        : (one_shot ? ret_mode : state);
                  xpmc_pkg::XPMC_C_CLR:
                     next_state = xpmc_pkg::XPMC_CMD;
                  default:
                     next_state = one_shot ? ret_mode : state;
               endcase
            end
         end
         xpmc_pkg::XPMC_CIP:
         begin
            if (take && is_recall)
            begin
               next_state = xpmc_pkg::XPMC_CMD;
            end
            else if (call_ok)
            begin
               next_state = xpmc_pkg::XPMC_DATA;
            end
            else if (call_fail)
            begin
               next_state = xpmc_pkg::XPMC_CMD;
            end
         end
         xpmc_pkg::XPMC_DATA:
         begin
            if (take && is_recall)
            begin
               next_state = xpmc_pkg::XPMC_CMD;
            end
            else if (take && plus_cnt == 2'(xpmc_pkg::ESC_LEN - 1)
               && is_plus)
            begin
               next_state = xpmc_pkg::XPMC_AT;
            end
         end
         default:
            next_state = xpmc_pkg::XPMC_AT;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state <= xpmc_pkg::XPMC_AT;
      end
      else if (enable)
      begin
         state <= next_state;
      end
   end
   assign mode = state;

   // Autostart is looked at once after each restart only
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         auto_seen <= 1'b0;
      end
      else if (enable)
      begin
         auto_seen <= 1'b1;
      end
   end

   // Recall arms a single command, then the old mode returns, unless it is clear or a select with link
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         one_shot <= 1'b0;
         ret_mode <= xpmc_pkg::XPMC_DATA;
      end
      else if (enable)
      begin
         if (take && is_recall)
         begin
            one_shot <= 1'b1;
            ret_mode <= state;
         end
         else if (state == xpmc_pkg::XPMC_CMD && cmd_valid)
         begin
            one_shot <= 1'b0;
         end
      end
   end

   // Escape counter; any other character restarts it
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         plus_cnt <= '0;
      end
      else if (enable && take)
      begin
         // Restart after a full escape so the next +++ is seen again
         plus_cnt <= is_plus && plus_cnt != 2'(xpmc_pkg::ESC_LEN - 1)
            ? plus_cnt + 2'd1 : 2'd0;
      end
   end

   // ------
   // Command line length check
   // ------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         line_cnt <= '0;
         line_overflow <= 1'b0;
         line_end <= 1'b0;
      end
      else if (enable)
      begin
         line_end <= take && state == xpmc_pkg::XPMC_CMD && is_delim;
         if (take && state == xpmc_pkg::XPMC_CMD)
         begin
            if (is_delim)
            begin
               line_cnt <= '0;
               line_overflow <= 1'b0;
            end
            else if (line_cnt == 8'(xpmc_pkg::LINE_MAX))
            begin
               line_overflow <= 1'b1;
            end
            else
            begin
               line_cnt <= line_cnt + 8'd1;
            end
         end
      end
   end

   // ------
   // Responses, echo, network requests
   // ------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         resp_code <= xpmc_pkg::XPMC_R_NONE;
         resp_valid <= 1'b0;
         prompt_due <= 1'b0;
         echo_valid <= 1'b0;
         echo_data <= '0;
         call_request <= 1'b0;
         clear_request <= 1'b0;
         save_request <= 1'b0;
      end
      else if (enable)
      begin
         resp_valid <= 1'b1;
         prompt_due <= 1'b0;
         resp_code <= xpmc_pkg::XPMC_R_NONE;
         call_request <= 1'b0;
         clear_request <= 1'b0;
         save_request <= 1'b0;
         echo_valid <= take && !is_recall && state != xpmc_pkg::XPMC_AT;
         echo_data <= term_data;
         if (state == xpmc_pkg::XPMC_AT && cmd_valid
            && cmd_code == xpmc_pkg::XPMC_C_RESUME && !link_up)
         begin
            resp_code <= xpmc_pkg::XPMC_R_ERROR;
         end
         else if (state == xpmc_pkg::XPMC_CIP && next_state
            == xpmc_pkg::XPMC_DATA)
         begin
            resp_code <= xpmc_pkg::XPMC_R_COM;
         end
         else if (state == xpmc_pkg::XPMC_CMD && cmd_valid
            && (cmd_code == xpmc_pkg::XPMC_C_BAD || line_overflow))
         begin
            resp_code <= xpmc_pkg::XPMC_R_ERR;
         end
         else if (state == xpmc_pkg::XPMC_CMD && cmd_valid
            && cmd_code == xpmc_pkg::XPMC_C_CLR)
         begin
            resp_code <= one_shot || ret_mode == xpmc_pkg::XPMC_DATA
               ? xpmc_pkg::XPMC_R_CLRCONF : xpmc_pkg::XPMC_R_CLRERR;
            clear_request <= 1'b1;
            prompt_due <= 1'b1;
         end
         else if (prompt_due || next_state == xpmc_pkg::XPMC_CMD
            && state != xpmc_pkg::XPMC_CMD)
         begin
            resp_code <= xpmc_pkg::XPMC_R_PROMPT;
         end
         else
         begin
            resp_valid <= 1'b0;
         end
         if (state == xpmc_pkg::XPMC_CMD && cmd_valid
            && cmd_code == xpmc_pkg::XPMC_C_SEL && link_up)
         begin
            call_request <= 1'b1;
         end
         if (cmd_valid && cmd_code == xpmc_pkg::XPMC_C_SAVE)
         begin
            save_request <= 1'b1;
         end
         if (state == xpmc_pkg::XPMC_AT && cmd_valid
            && cmd_code == xpmc_pkg::XPMC_C_HANGUP)
         begin
            clear_request <= 1'b1;
         end
      end
   end

   // Link stays requested while the D-packet service is subscribed
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         link_request <= 1'b0;
      end
      else if (enable)
      begin
         link_request <= dpkt_subscribed;
      end
   end

   // ------
   // Packet data path and window limits
   // ------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         send_seq <= '0;
         pkt_len <= '0;
         window_open <= 1'b0;
      end
      else if (enable)
      begin
         window_open <= link_outstanding < 4'(xpmc_pkg::WIN_MAX)
            && pkt_outstanding < 4'(xpmc_pkg::WIN_MAX);
         if (to_pkt)
         begin
            if (pkt_len == 9'(xpmc_pkg::PKT_MAX - 1))
            begin
               pkt_len <= '0;
               send_seq <= 3'(send_seq + 3'd1);
            end
            else
            begin
               pkt_len <= pkt_len + 9'd1;
            end
         end
      end
   end

   // Valid while data waits and the window is open; valid and ready mean a beat only while enable is high
   assign pkt_valid = fifo_out_valid && window_open;

   // Data waits here while the network window is closed
   xpmc_fifo #(
      .WIDTH(xpmc_pkg::CHAR_W),
      .DEPTH(xpmc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .enable(enable),
      .in_valid(to_pkt),
      .in_ready(fifo_in_ready),
      .in_data(term_data),
      .out_valid(fifo_out_valid),
      .out_ready(pkt_ready && window_open),
      .out_data(pkt_data)
   );

   // ------
   // Checks
   // ------
   prompt_on_entry_a: assert property (@(posedge clock) disable iff (reset)
      enable && state != xpmc_pkg::XPMC_CMD && next_state == xpmc_pkg::XPMC_CMD
      && !cmd_valid |=> resp_valid && resp_code == xpmc_pkg::XPMC_R_PROMPT)
      else $error("no prompt on command mode entry");
   recall_escape_a: assert property (@(posedge clock) disable iff (reset)
      enable && take && is_recall |=> state == xpmc_pkg::XPMC_CMD)
      else $error("recall did not reach command mode");
   recall_not_sent_a: assert property (@(posedge clock) disable iff (reset)
      take && is_recall |-> !to_pkt)
      else $error("recall entered packet stream");
   resume_no_link_a: assert property (@(posedge clock) disable iff (reset)
      enable && auto_seen && state == xpmc_pkg::XPMC_AT && cmd_valid
      && cmd_code == xpmc_pkg::XPMC_C_RESUME && !link_up
      |=> state == xpmc_pkg::XPMC_AT
      && resp_code == xpmc_pkg::XPMC_R_ERROR)
      else $error("resume without link left AT mode");
   com_on_connect_a: assert property (@(posedge clock) disable iff (reset)
      enable && state == xpmc_pkg::XPMC_CIP && !take && call_ok
      |=> state == xpmc_pkg::XPMC_DATA && resp_code == xpmc_pkg::XPMC_R_COM)
      else $error("COM missing on call established");
   clear_stays_cmd_a: assert property (@(posedge clock) disable iff (reset)
      enable && state == xpmc_pkg::XPMC_CMD && !take && cmd_valid
      && cmd_code == xpmc_pkg::XPMC_C_CLR
      |=> state == xpmc_pkg::XPMC_CMD && clear_request)
      else $error("clear did not stay in command mode");
   window_limit_a: assert property (@(posedge clock) disable iff (reset)
      enable && link_outstanding >= 4'(xpmc_pkg::WIN_MAX) |=> !window_open)
      else $error("window open at limit");
   packet_length_a: assert property (@(posedge clock) disable iff (reset)
      pkt_len < 9'(xpmc_pkg::PKT_MAX))
      else $error("packet length over limit");
   mode_legal_a: assert property (@(posedge clock) disable iff (reset)
      state inside {xpmc_pkg::XPMC_AT, xpmc_pkg::XPMC_CMD,
      xpmc_pkg::XPMC_CIP, xpmc_pkg::XPMC_DATA})
      else $error("illegal mode");
endmodule : xpmc_ctrl
`default_nettype wire

// File: hdl/xpmc_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from a separate occupancy count
`timescale 1ns/1ps
`default_nettype none
module xpmc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic enable,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = enable && in_valid && in_ready;
   assign pop = enable && out_valid && out_ready;

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : xpmc_fifo
`default_nettype wire

// File: hdl/xpmc_pkg.sv
// Purpose: Shared constants and types for the PAD mode controller
// Assumes: 8-bit terminal characters, 50 MHz clock
// Notes: Commands arrive already decoded from a command line buffer
package xpmc_pkg;
   localparam int unsigned CHAR_W = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned LINE_MAX = 128;
   localparam int unsigned PKT_MAX = 256;
   localparam int unsigned WIN_MAX = 7;
   localparam int unsigned SEQ_MOD = 8;
   localparam logic [7:0] RECALL_DEF = 8'h10;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_PLUS = 8'h2B;
   localparam logic [7:0] CH_STAR = 8'h2A;
   localparam int unsigned ESC_LEN = 3;

   // Top-level operating modes
   typedef enum logic [2:0] {
      XPMC_AT, XPMC_CMD, XPMC_CIP, XPMC_DATA
   } xpmc_mode_e;

   // Decoded command codes from the line parser
   typedef enum logic [2:0] {
      XPMC_C_NONE, XPMC_C_SEL, XPMC_C_CLR, XPMC_C_RESUME,
      XPMC_C_HANGUP, XPMC_C_SAVE, XPMC_C_OTHER, XPMC_C_BAD
   } xpmc_cmd_e;

   // Service signals sent to the terminal
   typedef enum logic [2:0] {
      XPMC_R_NONE, XPMC_R_PROMPT, XPMC_R_COM, XPMC_R_CLRCONF,
      XPMC_R_ERROR, XPMC_R_ERR, XPMC_R_CLRERR
   } xpmc_resp_e;
endpackage : xpmc_pkg

// File: tb/x25_pad_mode_controller_tb.sv
// Purpose: Self-checking bench for the PAD mode controller
// Assumes: Recall character at its default, enable held high
// Notes: Monitors collect echoes, packets and service signals
`timescale 1ns/1ps
`default_nettype none
module x25_pad_mode_controller_tb;
   // ------
   // Signals
   // ------
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic term_valid = 1'b0;
   logic [7:0] term_data = 8'h00;
   logic cmd_valid = 1'b0;
   xpmc_pkg::xpmc_cmd_e cmd_code = xpmc_pkg::XPMC_C_NONE;
   logic autostart = 1'b0;
   logic dpkt_subscribed = 1'b0;
   logic pkt_ready = 1'b1;
   logic [3:0] link_outstanding = 4'h0;
   logic [3:0] pkt_outstanding = 4'h0;
   logic fail_next = 1'b0;
   logic term_ready, link_up_pin, call_ok_pin, call_fail_pin;
   logic link_request, call_request, clear_request, save_request;
   logic line_end, line_overflow, echo_valid, resp_valid;
   logic pkt_valid, window_open;
   logic [7:0] echo_data, pkt_data;
   xpmc_pkg::xpmc_resp_e resp_code;
   logic [2:0] mode, send_seq;
   logic [8:0] pkt_len;
   int fails = 0;
   int samples_checked = 0;
   logic [7:0] resp_seen = 8'h00;
   logic [7:0] echoes[$];
   logic [7:0] pkts[$];
   int line_ends = 0;
   int saves = 0;
   int clears = 0;
   int n;

   always #10 clock = ~clock;

   xpmc_ctrl xpmc_ctrl_i (.clock(clock), .reset(reset), .enable(1'b1),
      .term_valid(term_valid), .term_data(term_data),
      .term_ready(term_ready), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .recall_char(xpmc_pkg::RECALL_DEF),
      .autostart(autostart), .dpkt_subscribed(dpkt_subscribed),
      .link_up_pin(link_up_pin), .call_ok_pin(call_ok_pin),
      .call_fail_pin(call_fail_pin), .link_request(link_request),
      .call_request(call_request), .clear_request(clear_request),
      .save_request(save_request), .line_end(line_end),
      .line_overflow(line_overflow), .echo_data(echo_data),
      .echo_valid(echo_valid), .resp_code(resp_code),
      .resp_valid(resp_valid), .mode(mode), .pkt_valid(pkt_valid),
      .pkt_ready(pkt_ready), .pkt_data(pkt_data),
      .link_outstanding(link_outstanding),
      .pkt_outstanding(pkt_outstanding), .send_seq(send_seq),
      .window_open(window_open), .pkt_len(pkt_len));

   xpmc_net_model xpmc_net_model_i (.clock(clock), .reset(reset),
      .link_request(link_request), .call_request(call_request),
      .clear_request(clear_request), .fail_next(fail_next),
      .link_up_pin(link_up_pin), .call_ok_pin(call_ok_pin),
      .call_fail_pin(call_fail_pin));

   // ------
   // Monitors and helpers
   // ------
   always @(posedge clock)
   begin
      if (resp_valid === 1'b1)
         resp_seen[resp_code] <= 1'b1;
      if (echo_valid === 1'b1)
         echoes.push_back(echo_data);
      if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
         pkts.push_back(pkt_data);
      if (line_end === 1'b1)
         line_ends++;
      if (save_request === 1'b1)
         saves++;
      if (clear_request === 1'b1)
         clears++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic chkmode(input xpmc_pkg::xpmc_mode_e m);
      check(16'(mode), 16'(m));
   endtask : chkmode

   task automatic chkresp(input xpmc_pkg::xpmc_resp_e r);
      check(16'(resp_seen[r]), 16'h1);
   endtask : chkresp

   task automatic clr;
      @(negedge clock);
      resp_seen = 8'h00;
      echoes.delete();
      pkts.delete();
      line_ends = 0;
      saves = 0;
      clears = 0;
   endtask : clr

   // Leaves room for the answer and the following prompt to land
   task automatic cmd(input xpmc_pkg::xpmc_cmd_e c);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      @(posedge clock);
      cmd_valid <= 1'b0;
      repeat (5) @(posedge clock);
   endtask : cmd

   task automatic chr(input logic [7:0] c);
      int k;
      k = 0;
      @(posedge clock);
      term_valid <= 1'b1;
      term_data <= c;
      @(posedge clock);
      while (term_ready !== 1'b1 && k < 100)
      begin
         @(posedge clock);
         k++;
      end
      term_valid <= 1'b0;
      check(16'(k < 100), 16'h1);
   endtask : chr

   task automatic wmode(input xpmc_pkg::xpmc_mode_e m);
      int k;
      k = 0;
      while (mode !== m && k < 50)
      begin
         @(posedge clock);
         k++;
      end
      repeat (3) @(posedge clock);
   endtask : wmode

   // ------
   // Scenarios
   // ------
   task automatic t_boot;
      @(posedge clock);
      autostart <= 1'b1;
      repeat (4) @(posedge clock);
      chkmode(xpmc_pkg::XPMC_AT);
      clr();
      cmd(xpmc_pkg::XPMC_C_RESUME);
      chkresp(xpmc_pkg::XPMC_R_ERROR);
      chkmode(xpmc_pkg::XPMC_AT);
      dpkt_subscribed <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(link_request), 16'h1);
      clr();
      cmd(xpmc_pkg::XPMC_C_RESUME);
      chkmode(xpmc_pkg::XPMC_CMD);
      chkresp(xpmc_pkg::XPMC_R_PROMPT);
      $display("boot test done");
   endtask : t_boot

   task automatic t_call;
      clr();
      fail_next <= 1'b1;
      cmd(xpmc_pkg::XPMC_C_SEL);
      chkmode(xpmc_pkg::XPMC_CIP);
      wmode(xpmc_pkg::XPMC_CMD);
      chkmode(xpmc_pkg::XPMC_CMD);
      chkresp(xpmc_pkg::XPMC_R_PROMPT);
      clr();
      fail_next <= 1'b0;
      cmd(xpmc_pkg::XPMC_C_SEL);
      chkmode(xpmc_pkg::XPMC_CIP);
      wmode(xpmc_pkg::XPMC_DATA);
      chkmode(xpmc_pkg::XPMC_DATA);
      chkresp(xpmc_pkg::XPMC_R_COM);
      $display("call test done");
   endtask : t_call

   task automatic t_data;
      clr();
      chr(8'h41);
      chr(8'h42);
      chr(xpmc_pkg::RECALL_DEF);
      repeat (4) @(posedge clock);
      chkmode(xpmc_pkg::XPMC_CMD);
      chkresp(xpmc_pkg::XPMC_R_PROMPT);
      check(16'(echoes.size()), 16'h2);
      check({echoes[0], echoes[1]}, 16'h4142);
      check(16'(pkts.size()), 16'h2);
      check({pkts[0], pkts[1]}, 16'h4142);
      cmd(xpmc_pkg::XPMC_C_OTHER);
      chkmode(xpmc_pkg::XPMC_DATA);
      $display("data test done");
   endtask : t_data

   task automatic t_window;
      pkt_outstanding <= 4'h7;
      repeat (3) @(posedge clock);
      check(16'(window_open), 16'h0);
      pkt_outstanding <= 4'h6;
      link_outstanding <= 4'h7;
      repeat (3) @(posedge clock);
      check(16'(window_open), 16'h0);
      clr();
      @(posedge clock);
      n = 0;
      term_valid <= 1'b1;
      term_data <= 8'h30;
      repeat (24)
      begin
         @(posedge clock);
         if (term_ready === 1'b1)
         begin
            n++;
            term_data <= 8'h30 + 8'(n);
         end
      end
      term_valid <= 1'b0;
      check(16'(n), 16'(xpmc_pkg::FIFO_DEPTH));
      check(16'(pkts.size()), 16'h0);
      link_outstanding <= 4'h6;
      repeat (3) @(posedge clock);
      check(16'(window_open), 16'h1);
      // Far side stalls every other cycle while the buffer drains
      repeat (60) @(posedge clock) pkt_ready <= ~pkt_ready;
      pkt_ready <= 1'b1;
      repeat (4) @(posedge clock);
      check(16'(pkts.size()), 16'(n));
      foreach (pkts[i]) check(16'(pkts[i]), 16'(8'h30 + 8'(i)));
      $display("window test done");
   endtask : t_window

   task automatic t_clear;
      chr(xpmc_pkg::RECALL_DEF);
      repeat (4) @(posedge clock);
      clr();
      cmd(xpmc_pkg::XPMC_C_CLR);
      check(16'(clears), 16'h1);
      chkresp(xpmc_pkg::XPMC_R_CLRCONF);
      chkresp(xpmc_pkg::XPMC_R_PROMPT);
      chkmode(xpmc_pkg::XPMC_CMD);
      clr();
      cmd(xpmc_pkg::XPMC_C_BAD);
      chkresp(xpmc_pkg::XPMC_R_ERR);
      $display("clear test done");
   endtask : t_clear

   task automatic t_line;
      clr();
      repeat (xpmc_pkg::LINE_MAX) chr(8'h41);
      repeat (3) @(posedge clock);
      check(16'(line_overflow), 16'h0);
      check(16'(echoes.size()), 16'(xpmc_pkg::LINE_MAX));
      chr(8'h41);
      repeat (3) @(posedge clock);
      check(16'(line_overflow), 16'h1);
      chr(xpmc_pkg::CH_CR);
      repeat (3) @(posedge clock);
      check(16'(line_ends), 16'h1);
      check(16'(line_overflow), 16'h0);
      $display("line test done");
   endtask : t_line

   task automatic t_escape;
      clr();
      repeat (3) chr(xpmc_pkg::CH_PLUS);
      repeat (4) @(posedge clock);
      chkmode(xpmc_pkg::XPMC_AT);
      check(16'(line_ends > 0), 16'h1);
      cmd(xpmc_pkg::XPMC_C_RESUME);
      chkmode(xpmc_pkg::XPMC_CMD);
      repeat (3) chr(xpmc_pkg::CH_PLUS);
      cmd(xpmc_pkg::XPMC_C_HANGUP);
      check(16'(clears), 16'h1);
      chkmode(xpmc_pkg::XPMC_AT);
      $display("escape test done");
   endtask : t_escape

   task automatic t_auto;
      clr();
      @(posedge clock);
      reset <= 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      repeat (5) @(posedge clock);
      chkmode(xpmc_pkg::XPMC_CMD);
      chkresp(xpmc_pkg::XPMC_R_PROMPT);
      cmd(xpmc_pkg::XPMC_C_SAVE);
      check(16'(saves), 16'h1);
      $display("autostart test done");
   endtask : t_auto

   // ------
   // Run control
   // ------
   task automatic final_report;
      $display("compared %0d, mismatched %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      t_boot();
      t_call();
      t_data();
      t_window();
      t_clear();
      t_line();
      t_escape();
      t_auto();
      final_report();
   end

   // The tests need well under a thousand cycles; this leaves ample margin
   initial
   begin
      repeat (20000) @(posedge clock);
      fails++;
      final_report();
   end
endmodule : x25_pad_mode_controller_tb
`default_nettype wire

// File: tb/xpmc_net_model.sv
// Purpose: Behavioural network side: D-channel link and call outcome
// Assumes: Call and clear requests from the controller are one-cycle pulses; link request is a level
// Notes: OK pin is a level, fail pin is held a few cycles; both late enough to see connect in progress
`timescale 1ns/1ps
`default_nettype none
module xpmc_net_model #(
   parameter int DLY = 6
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic link_request,
   input wire logic call_request,
   input wire logic clear_request,
   input wire logic fail_next,
   output logic link_up_pin,
   output logic call_ok_pin,
   output logic call_fail_pin
);
   // ------
   // Link and call answers
   // ------
   int cnt;
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         link_up_pin <= 1'b0;
         call_ok_pin <= 1'b0;
         call_fail_pin <= 1'b0;
         cnt <= 0;
      end
      else
      begin
         link_up_pin <= link_request;
         if (call_request)
         begin
            cnt <= DLY;
            call_fail_pin <= 1'b0;
         end
         else if (cnt > 1)
            cnt <= cnt - 1;
         else if (cnt == 1)
         begin
            // Failure is held a few cycles so the synchroniser sees it
            cnt <= fail_next ? -4 : 0;
            call_ok_pin <= !fail_next;
            call_fail_pin <= fail_next;
         end
         else if (cnt < 0)
            cnt <= cnt + 1;
         else
            call_fail_pin <= 1'b0;
         if (clear_request)
            call_ok_pin <= 1'b0;
      end
   end
endmodule : xpmc_net_model
`default_nettype wire
